//--- verilog/event_triggered_sample_buffer.sv
`include "sample_buffer_cfg.svh"
`default_nettype none

module event_triggered_sample_buffer #(
    parameter int DEPTH = 256,
    parameter logic [7:0] EMPTY_TAG = 8'hff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire sample_buffer_pkg::sample_s sample,
    input wire sample_buffer_pkg::detect_s detect,
    output logic full_flag,
    output logic trig_fired
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [8:0] DEPTH_W = 9'(DEPTH);

    function automatic logic is_mapped(input logic [7:0] i);
        return (i == `OFS_HIGHG_EN) || (i == `OFS_THRESHOLD) || (i == `OFS_CONTROL) ||
               (i == `OFS_ROUTE) || (i == `OFS_STATUS_LOW) || (i == `OFS_STATUS_HIGH) ||
               (i >= `OFS_OUT_TAG && i <= `OFS_BURST);
    endfunction

    function automatic logic is_trig_mode(input logic [2:0] m);
        return (m == `MODE_BYP_CONT) || (m == `MODE_BYP_FIFO) ||
               (m == `MODE_CWTM_FULL) || (m == `MODE_CONT_FIFO);
    endfunction

    function automatic sample_buffer_pkg::beh_e beh_of(input logic [2:0] m, input logic f);
        case (m)
            `MODE_FIFO: return sample_buffer_pkg::beh_fifo;
            `MODE_CONT: return sample_buffer_pkg::beh_cont;
            `MODE_BYP_CONT: return f ? sample_buffer_pkg::beh_cont : sample_buffer_pkg::beh_idle;
            `MODE_BYP_FIFO: return f ? sample_buffer_pkg::beh_fifo : sample_buffer_pkg::beh_idle;
            `MODE_CWTM_FULL,
            `MODE_CONT_FIFO: return f ? sample_buffer_pkg::beh_fifo : sample_buffer_pkg::beh_cont;
            default: return sample_buffer_pkg::beh_idle;
        endcase
    endfunction

    function automatic logic [7:0] byte_of(input sample_buffer_pkg::sample_s w,
                                           input logic [2:0] k);
        logic [7:0] b;
        b = 8'h00;
        if (k == 3'h0) begin
            b = w.tag;
        end else if (k <= `LAST_BYTE) begin
            b = w.data[8*(k-3'h1) +: 8];
        end
        return b;
    endfunction

    function automatic logic [2:0] byte_next(input logic [2:0] k);
        return (k >= `LAST_BYTE) ? 3'h0 : k + 3'h1;
    endfunction

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (32'(p) == DEPTH - 1) ? '0 : p + 1'b1;
    endfunction

    sample_buffer_pkg::sample_s mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [8:0] cnt_q;
    logic [2:0] mode_q;
    logic [7:0] wtm_q;
    logic [4:0] route_q;
    logic highg_q;
    sample_buffer_pkg::trig_state_e trg_q;
    logic evt_prev_q;
    logic full_q;
    logic ovr_q;
    logic stop_q;
    logic [2:0] bptr_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic rdv_q;

    // Bus decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_q;
    wire [7:0] idx = paddr[9:2];
    wire hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && is_mapped(idx);
    wire wr_en = access & pwrite & pstrb[0] & hit;
    wire rd_en = access & ~pwrite & hit;
    wire mode_wr = wr_en && (idx == `OFS_CONTROL);
    wire bypass_wr = mode_wr && (pwdata[2:0] == `MODE_BYPASS);
    wire is_out = (idx >= `OFS_OUT_TAG) && (idx <= `OFS_OUT_ZH);
    wire [2:0] out_k = 3'(idx - `OFS_OUT_TAG);

    // Trigger source and edge
    wire evt = |({detect.single_tap, detect.double_tap, detect.freefall,
                  detect.wakeup, detect.orientation} & route_q) |
               (detect.highg_wakeup & highg_q);
    wire evt_edge = evt & ~evt_prev_q;
    wire fired = (trg_q == sample_buffer_pkg::trg_fired);
    wire fire = is_trig_mode(mode_q) && evt_edge && !fired && !bypass_wr;

    // Behaviour selection and capacity
    sample_buffer_pkg::beh_e beh;
    assign beh = beh_of(mode_q, fired);
    wire cwtm_pre = (mode_q == `MODE_CWTM_FULL) && !fired;
    // A zero watermark would leave no room at all, so keep one slot
    wire [8:0] cap = cwtm_pre ? ((wtm_q == 8'h00) ? 9'h001 : {1'b0, wtm_q}) : DEPTH_W;
    wire at_cap = (cnt_q >= cap);
    wire bypassing = (mode_q == `MODE_BYPASS);

    // Readout
    wire pop_req = rd_en && ((idx == `OFS_OUT_ZH) ||
                             ((idx == `OFS_BURST) && (bptr_q == `LAST_BYTE)));
    // Only pop a word that was really shown in the setup cycle
    wire pop = pop_req && rdv_q && (cnt_q != 9'h000);

    // Storage
    wire blocked = (beh == sample_buffer_pkg::beh_idle) ||
                   ((beh == sample_buffer_pkg::beh_fifo) && (at_cap || stop_q));
    wire store = sample_valid && !blocked && !bypassing;
    wire overwrite = store && (beh == sample_buffer_pkg::beh_cont) && at_cap && !pop;
    wire [8:0] cnt_d = cnt_q + 9'(store) - 9'(pop) - 9'(overwrite);
    wire full_set = store && !cwtm_pre && (cnt_d >= cap);
    // A buffer already full when fifo behaviour starts must stop as well
    wire stop_set = (beh == sample_buffer_pkg::beh_fifo) && (full_set || at_cap);

    sample_buffer_pkg::sample_s head;
    assign head = (cnt_q == 9'h000) ? {EMPTY_TAG, 48'h0} : mem[rd_ptr_q];

    wire [7:0] st_high = (8'(cnt_q[8]) << `ST2_CNT8_BIT) |
                         (8'(fired) << `ST2_FIRED_BIT) |
                         (8'(stop_q) << `ST2_STOP_BIT) |
                         (8'(ovr_q) << `ST2_OVR_BIT) |
                         (8'(full_q) << `ST2_FULL_BIT);

    wire [7:0] rd_byte =
        (idx == `OFS_HIGHG_EN) ? {7'h00, highg_q} :
        (idx == `OFS_THRESHOLD) ? wtm_q :
        (idx == `OFS_CONTROL) ? {5'h00, mode_q} :
        (idx == `OFS_ROUTE) ? {3'h0, route_q} :
        (idx == `OFS_STATUS_LOW) ? cnt_q[7:0] :
        (idx == `OFS_STATUS_HIGH) ? st_high :
        (idx == `OFS_BURST) ? byte_of(head, bptr_q) :
        is_out ? byte_of(head, out_k) : 8'h00;

    // Bus answer: ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            rdv_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pready_q <= 1'b1;
            pslverr_q <= !hit;
            rdv_q <= (cnt_q != 9'h000);
        end else if (access) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `RST_MODE;
            wtm_q <= `RST_WTM;
            route_q <= `RST_ROUTE;
            highg_q <= `RST_HIGHG;
        end else if (wr_en) begin
            if (idx == `OFS_CONTROL) begin
                mode_q <= pwdata[2:0];
            end
            if (idx == `OFS_THRESHOLD) begin
                wtm_q <= pwdata[7:0];
            end
            if (idx == `OFS_ROUTE) begin
                route_q <= pwdata[4:0];
            end
            if (idx == `OFS_HIGHG_EN) begin
                highg_q <= pwdata[0];
            end
        end
    end

    // Trigger state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_q <= sample_buffer_pkg::trg_armed;
            evt_prev_q <= 1'b0;
        end else begin
            evt_prev_q <= evt;
            case (trg_q)
                sample_buffer_pkg::trg_armed: begin
                    if (fire) begin
                        trg_q <= sample_buffer_pkg::trg_fired;
                    end
                end
                sample_buffer_pkg::trg_fired: begin
                    if (bypass_wr) begin
                        trg_q <= sample_buffer_pkg::trg_armed;
                    end
                end
                default: trg_q <= sample_buffer_pkg::trg_armed;
            endcase
        end
    end

    // Pointers, count and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= 9'h000;
            full_q <= 1'b0;
            ovr_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (bypassing) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= 9'h000;
            full_q <= 1'b0;
            ovr_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            if (store) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (pop || overwrite) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            cnt_q <= cnt_d;
            // Set wins over the clear that a read brings
            full_q <= full_set | (full_q & ~pop & ~bypass_wr);
            ovr_q <= overwrite | (ovr_q & ~bypass_wr);
            stop_q <= stop_set | (stop_q & ~bypass_wr);
        end
    end

    always_ff @(posedge pclk) begin
        if (store) begin
            mem[wr_ptr_q] <= sample;
        end
    end

    // Byte pointer of the auto-wrapping burst port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bptr_q <= 3'h0;
        end else if (bypass_wr) begin
            bptr_q <= 3'h0;
        end else if (rd_en && (idx == `OFS_BURST)) begin
            bptr_q <= byte_next(bptr_q);
        end else if (rd_en && is_out) begin
            bptr_q <= byte_next(out_k);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign full_flag = full_q;
    assign trig_fired = fired;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_bypass_empty: assert property (bypassing |=> cnt_q == 9'h000)
        else $error("bypass did not empty the buffer");
    chk_edge_fires: assert property (is_trig_mode(mode_q) && evt && !evt_prev_q
        && !bypass_wr |=> trg_q == sample_buffer_pkg::trg_fired)
        else $error("trigger edge not taken");
    chk_fired_sticky: assert property (fired && !bypass_wr |=> fired)
        else $error("fired state lost without bypass");
    chk_level_no_fire: assert property (!fired && evt && evt_prev_q |=> !fired)
        else $error("steady level fired the trigger");
    chk_prefire_empty: assert property (((mode_q == `MODE_BYP_CONT) ||
        (mode_q == `MODE_BYP_FIFO)) && !fired && cnt_q == 9'h000 |=> cnt_q == 9'h000)
        else $error("stored before trigger");
    chk_fifo_holds: assert property (beh == sample_buffer_pkg::beh_fifo && stop_q && !pop
        && !mode_wr |=> cnt_q == $past(cnt_q))
        else $error("fifo kept collecting after stop");
    chk_wtm_cap: assert property (cwtm_pre && !mode_wr && cnt_q <= cap
        |=> cnt_q <= $past(cap))
        else $error("watermark capacity exceeded");
    chk_full_masked: assert property (cwtm_pre && !full_q && !mode_wr |=> !full_q)
        else $error("full flag rose while masked");
    chk_full_rises: assert property (beh == sample_buffer_pkg::beh_cont && !cwtm_pre
        && store && at_cap && !pop |=> full_q && ovr_q)
        else $error("overrun did not raise full");
    chk_empty_tag: assert property (setup && hit && idx == `OFS_OUT_TAG
        && cnt_q == 9'h000 |=> prdata_q[7:0] == EMPTY_TAG)
        else $error("empty read lacks empty tag");
    chk_pop_count: assert property (pop && !store |=> cnt_q == $past(cnt_q) - 9'h001)
        else $error("read did not free a slot");
    chk_burst_wrap: assert property (rd_en && idx == `OFS_BURST && bptr_q == `LAST_BYTE
        && !bypass_wr |=> bptr_q == 3'h0)
        else $error("burst pointer did not wrap to tag");
    chk_cont_overwrite: assert property (beh == sample_buffer_pkg::beh_cont && store
        && at_cap && !pop |=> cnt_q == $past(cnt_q) && ovr_q)
        else $error("continuous store did not overwrite oldest");
    chk_rearm_bypass: assert property (bypass_wr |=> !fired)
        else $error("bypass did not rearm the trigger");
    chk_status_count: assert property (setup && hit && idx == `OFS_STATUS_LOW
        |=> prdata_q[7:0] == $past(cnt_q[7:0]))
        else $error("status low differs from word count");

endmodule
`default_nettype wire

//--- verilog/sample_buffer_cfg.svh
`ifndef SAMPLE_BUFFER_CFG_SVH
`define SAMPLE_BUFFER_CFG_SVH

// Register indices; byte address is four times the index
`define OFS_HIGHG_EN 8'h02
`define OFS_THRESHOLD 8'h07
`define OFS_CONTROL 8'h0a
`define OFS_ROUTE 8'h11
`define OFS_STATUS_LOW 8'h1b
`define OFS_STATUS_HIGH 8'h1c
`define OFS_OUT_TAG 8'h78
`define OFS_OUT_ZH 8'h7e
`define OFS_BURST 8'h7f

// Buffer mode select codes
`define MODE_BYPASS 3'h0
`define MODE_FIFO 3'h1
`define MODE_CWTM_FULL 3'h2
`define MODE_CONT_FIFO 3'h3
`define MODE_BYP_CONT 3'h4
`define MODE_CONT 3'h6
`define MODE_BYP_FIFO 3'h7

// Reset values
`define RST_MODE 3'h0
`define RST_WTM 8'h00
`define RST_ROUTE 5'h00
`define RST_HIGHG 1'b0

// Status high field positions
`define ST2_CNT8_BIT 0
`define ST2_FIRED_BIT 1
`define ST2_STOP_BIT 2
`define ST2_OVR_BIT 6
`define ST2_FULL_BIT 7

// Index of the last byte in a word (tag is byte 0)
`define LAST_BYTE 3'h6

`endif

//--- verilog/sample_buffer_pkg.sv
`default_nettype none
package sample_buffer_pkg;

    typedef struct packed {
        logic [7:0] tag;
        logic [47:0] data;
    } sample_s;

    typedef struct packed {
        logic single_tap;
        logic double_tap;
        logic freefall;
        logic wakeup;
        logic orientation;
        logic highg_wakeup;
    } detect_s;

    typedef enum logic {trg_armed, trg_fired} trig_state_e;

    typedef enum logic [1:0] {beh_idle, beh_fifo, beh_cont} beh_e;

endpackage
`default_nettype wire

//--- tb/apb_host_model.sv
`default_nettype none
module apb_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic hung);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 16);
        r = prdata;
        hung = !pready;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- tb/event_triggered_sample_buffer_bench.sv
`include "sample_buffer_cfg.svh"
`default_nettype none
module event_triggered_sample_buffer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, full_flag, trig_fired, hung;
    logic sample_valid = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    sample_buffer_pkg::sample_s sample = '0;
    sample_buffer_pkg::detect_s detect = '0;
    sample_buffer_pkg::sample_s model[$];
    logic [32:0] expq[$];
    logic [31:0] seed = 32'hf5a1;
    int num_errors = 0;
    int total_checks = 0;
    int cap = DEPTH;
    always #50 pclk = ~pclk;
    event_triggered_sample_buffer #(.DEPTH(DEPTH)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample(sample), .detect(detect),
        .full_flag(full_flag), .trig_fired(trig_fired));
    apb_host_model host_u (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check("read data", prdata, expq[0][31:0]);
            check("read error", {31'h0, pslverr}, {31'h0, expq[0][32]});
            void'(expq.pop_front());
        end
    end
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic err = 1'b0);
        if (!w) expq.push_back({err, 24'h0, d});
        host_u.xfer(w, {2'b00, idx, 2'b00}, {24'h0, d}, rd_q, hung);
        if (hung) begin
            num_errors++;
            print_verdict();
        end
        if (!w) check("captured data", rd_q, {24'h0, d});
    endtask
    task automatic mode(input logic [2:0] m);
        bus(1'b1, `OFS_CONTROL, {5'h0, m});
        if (m == `MODE_BYPASS) model.delete();
    endtask
    task automatic rd_word(input logic burst);
        sample_buffer_pkg::sample_s w;
        logic [7:0] a;
        w = '{tag: 8'hff, data: 48'h0};
        if (model.size() > 0) w = model.pop_front();
        for (int k = 0; k < 7; k++) begin
            a = burst ? `OFS_BURST : 8'(`OFS_OUT_TAG + k);
            bus(1'b0, a, k == 0 ? w.tag : w.data[8*(k-1) +: 8]);
        end
    endtask
    task automatic push(input int n, input int how);
        sample_buffer_pkg::sample_s s;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            s = {8'(rnd() & 32'h7f), 16'(rnd()), rnd()};
            sample_valid <= 1'b1;
            sample <= s;
            if (how == 2 && model.size() == cap) void'(model.pop_front());
            if (how == 2 || (how == 1 && model.size() < cap)) model.push_back(s);
        end
        @(posedge pclk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic status(input logic [7:0] hi);
        bus(1'b0, `OFS_STATUS_LOW, 8'(model.size()));
        bus(1'b0, `OFS_STATUS_HIGH, hi);
    endtask
    task automatic pulse(input logic [5:0] d);
        @(posedge pclk);
        detect <= d;
        repeat (2) @(posedge pclk);
        detect <= '0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic flags(input logic t, input logic f);
        @(posedge pclk);
        check("trig_fired", {31'h0, trig_fired}, {31'h0, t});
        check("full_flag", {31'h0, full_flag}, {31'h0, f});
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        push(3, 0);
        status(8'h00);
        rd_word(1'b0);
        bus(1'b0, 8'h00, 8'h00, 1'b1);
        // Unrouted detector first, then the same one routed
        for (int i = 0; i < 5; i++) begin
            mode(`MODE_BYPASS);
            bus(1'b1, `OFS_ROUTE, 8'h00);
            mode(`MODE_BYP_FIFO);
            pulse(6'(2 << i));
            flags(1'b0, 1'b0);
            mode(`MODE_BYPASS);
            bus(1'b1, `OFS_ROUTE, 8'(1 << i));
            mode(`MODE_BYP_FIFO);
            pulse(6'(2 << i));
            flags(1'b1, 1'b0);
        end
        mode(`MODE_BYPASS);
        flags(1'b0, 1'b0);
        bus(1'b1, `OFS_ROUTE, 8'h10);
        @(posedge pclk);
        detect <= 6'h20;
        mode(`MODE_BYP_FIFO);
        push(3, 0);
        flags(1'b0, 1'b0);
        status(8'h00);
        detect <= '0;
        pulse(6'h20);
        push(10, 1);
        flags(1'b1, 1'b1);
        status(8'h86);
        rd_word(1'b1);
        rd_word(1'b1);
        push(4, 0);
        status(8'h06);
        pulse(6'h20);
        rd_word(1'b0);
        rd_word(1'b1);
        flags(1'b1, 1'b0);
        mode(`MODE_BYPASS);
        bus(1'b1, `OFS_ROUTE, 8'h00);
        bus(1'b1, `OFS_HIGHG_EN, 8'h01);
        mode(`MODE_BYP_CONT);
        push(3, 0);
        status(8'h00);
        pulse(6'h01);
        push(10, 2);
        flags(1'b1, 1'b1);
        status(8'hc2);
        rd_word(1'b1);
        rd_word(1'b1);
        mode(`MODE_BYPASS);
        bus(1'b1, `OFS_HIGHG_EN, 8'h00);
        bus(1'b1, `OFS_THRESHOLD, 8'h03);
        bus(1'b1, `OFS_ROUTE, 8'h01);
        cap = 3;
        mode(`MODE_CWTM_FULL);
        push(6, 2);
        flags(1'b0, 1'b0);
        bus(1'b0, `OFS_STATUS_LOW, 8'h03);
        pulse(6'h02);
        cap = DEPTH;
        push(10, 1);
        flags(1'b1, 1'b1);
        bus(1'b0, `OFS_STATUS_LOW, 8'(DEPTH));
        repeat (DEPTH + 1) rd_word(1'b1);
        bus(1'b0, `OFS_STATUS_LOW, 8'h00);
        // Continuous-to-fifo: already full at the trigger, so it stops at once
        mode(`MODE_BYPASS);
        mode(`MODE_CONT_FIFO);
        push(10, 2);
        flags(1'b0, 1'b1);
        pulse(6'h02);
        push(2, 1);
        rd_word(1'b1);
        push(2, 0);
        flags(1'b1, 1'b0);
        status(8'h46);
        print_verdict();
    end
endmodule
`default_nettype wire
